// >>> wdt_pkg.sv
`default_nettype none
package wdt_pkg;
    // Register byte offsets
    localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFF_STAT = 32'h0000_0004;
    localparam logic [31:0] OFF_MASK = 32'h0000_0008;
    localparam logic [31:0] OFF_FLAG = 32'h0000_000C;
    // Control field layout
    localparam int SWEN_BIT = 0;
    localparam int PS_LSB = 1;
    localparam int PS_MSB = 5;
    localparam logic [4:0] PS_DEFAULT = 5'h0B;
    // Event and flag bit positions
    localparam int EV_RESET_BIT = 0;
    localparam int EV_WAKE_BIT = 1;
    localparam int FLAG_EXP_BIT = 0;
    localparam int FLAG_PD_BIT = 1;
    // Mode encodings
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE_CONTROLLED = 2'h1;
    localparam logic [1:0] MODE_ACTIVE_AWAKE_ONLY = 2'h2;
    localparam logic [1:0] MODE_ALWAYS_ACTIVE = 2'h3;
    // Prescaler
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] PS_BASE = 24'h00_0020;
    localparam logic [4:0] PS_MAX_CODE = 5'h12;
    localparam int LF_OSC_KHZ = 31;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PH_AWAKE = 2'b00,
        PH_ASLEEP = 2'b01,
        PH_WAKING = 2'b11
    } wdt_phase_type;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic expire;
    } wdt_cnt_type;

    typedef struct packed {
        logic aw_have;
        logic [31:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] ps;
        logic swen;
        logic [1:0] status;
        logic [1:0] mask;
        logic expiry;
        logic powerdown;
        wdt_phase_type phase;
        logic sys_reset;
        logic wake;
        logic irq;
    } wdt_state_type;

    // Time-out length in oscillator ticks; reserved codes give minimum
    function automatic logic [CNT_W-1:0] wdt_period(input logic [4:0] code);
        if (code > PS_MAX_CODE) begin
            return PS_BASE;
        end
        return PS_BASE << code;
    endfunction : wdt_period

    // Watchdog active for a mode, software enable and sleep state
    function automatic logic wdt_active(input logic [1:0] mode,
                                        input logic swen,
                                        input logic asleep);
        case (mode)
            MODE_ALWAYS_ACTIVE: return 1'b1;
            MODE_ACTIVE_AWAKE_ONLY: return !asleep;
            MODE_SOFTWARE_CONTROLLED: return swen;
            default: return 1'b0;
        endcase
    endfunction : wdt_active
endpackage : wdt_pkg
`default_nettype wire

// >>> wdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_counter (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tick,
    input wire logic clear,
    input wire logic [4:0] sel,
    output var logic expire
);
    wdt_pkg::wdt_cnt_type r_reg;
    wdt_pkg::wdt_cnt_type r_next;
    logic [wdt_pkg::CNT_W-1:0] period;
    logic [wdt_pkg::CNT_W-1:0] last;

    // Period taken from the live select at each tick
    assign period = wdt_pkg::wdt_period(sel);
    assign last = period - 24'h00_0001;

    // Count oscillator ticks, wrap at the selected period
    always_comb begin
        r_next = r_reg;
        r_next.expire = 1'b0;
        if (clear) begin
            r_next.count = '0;
        end else if (tick) begin
            if (r_reg.count >= last) begin
                r_next.count = '0;
                r_next.expire = 1'b1;
            end else begin
                r_next.count = r_reg.count + 24'h00_0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign expire = r_reg.expire;

    AST_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        (ce && clear) |=> (r_reg.count == '0 && !expire))
        else $error("counter not cleared");
    AST_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
        (ce && tick && !clear && r_reg.count >= last) |=> expire)
        else $error("no expiry at selected period");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!nrst)
        (sel > wdt_pkg::PS_MAX_CODE) |-> (period == wdt_pkg::PS_BASE))
        else $error("reserved code not minimum period");
    AST_EARLY: assert property (@(posedge clk) disable iff (!nrst)
        (ce && tick && !clear && r_reg.count < last) |=> !expire)
        else $error("expiry before period");
endmodule : wdt_counter
`default_nettype wire

// >>> wdt_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [1:0] watchdog_mode_select,
    input wire logic lf_osc_tick,
    input wire logic clear_watchdog_instruction,
    input wire logic sleep_active,
    input wire logic osc_fail,
    input wire logic ost_running,
    output var logic system_reset,
    output var logic wake_request,
    output var logic expiry_flag,
    output var logic powerdown_flag,
    output var logic irq,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    wdt_pkg::wdt_state_type r_reg;
    wdt_pkg::wdt_state_type r_next;
    logic expire;
    logic asleep;
    logic active;
    logic enter_sleep;
    logic exit_sleep;
    logic cnt_clear;

    // Reset image of the whole state
    localparam wdt_pkg::wdt_state_type STATE_RESET = '{
        aw_have: 1'b0, aw_addr: 32'h0000_0000, w_have: 1'b0,
        w_data: 8'h00, w_lane0: 1'b0, awready: 1'b1, wready: 1'b1,
        bvalid: 1'b0, bresp: wdt_pkg::RESP_OKAY, arready: 1'b1,
        rvalid: 1'b0, rdata: 32'h0000_0000, rresp: wdt_pkg::RESP_OKAY,
        ps: wdt_pkg::PS_DEFAULT, swen: 1'b0, status: 2'h0, mask: 2'h0,
        expiry: 1'b0, powerdown: 1'b0, phase: wdt_pkg::PH_AWAKE,
        sys_reset: 1'b0, wake: 1'b0, irq: 1'b0
    };

    // Sleep phase and watchdog activity
    assign asleep = (r_reg.phase == wdt_pkg::PH_ASLEEP);
    assign active = wdt_pkg::wdt_active(watchdog_mode_select, r_reg.swen,
                                        asleep);
    assign enter_sleep = sleep_active && !asleep;
    assign exit_sleep = !sleep_active && asleep;

    // Clear sources; divider select deliberately not among them
    assign cnt_clear = !active || clear_watchdog_instruction
        || enter_sleep || exit_sleep
        || osc_fail
        || (ost_running && r_reg.phase == wdt_pkg::PH_WAKING);

    wdt_counter u_counter (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .tick(lf_osc_tick),
        .clear(cnt_clear),
        .sel(r_reg.ps),
        .expire(expire)
    );

    // Register read mux
    function automatic logic [31:0] rd_word(input wdt_pkg::wdt_state_type s,
                                            input logic [31:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (addr)
            wdt_pkg::OFF_CTRL: begin
                w[wdt_pkg::PS_MSB:wdt_pkg::PS_LSB] = s.ps;
                w[wdt_pkg::SWEN_BIT] = s.swen;
            end
            wdt_pkg::OFF_STAT: w[1:0] = s.status;
            wdt_pkg::OFF_MASK: w[1:0] = s.mask;
            wdt_pkg::OFF_FLAG: begin
                w[wdt_pkg::FLAG_EXP_BIT] = s.expiry;
                w[wdt_pkg::FLAG_PD_BIT] = s.powerdown;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : rd_word

    function automatic logic addr_ok(input logic [31:0] addr);
        return addr == wdt_pkg::OFF_CTRL || addr == wdt_pkg::OFF_STAT
            || addr == wdt_pkg::OFF_MASK || addr == wdt_pkg::OFF_FLAG;
    endfunction : addr_ok

    // Next-state logic: bus, registers, sleep phase, events
    always_comb begin
        logic [1:0] ev;
        logic [1:0] w1c;
        ev = 2'h0;
        w1c = 2'h0;
        r_next = r_reg;
        r_next.sys_reset = 1'b0;
        r_next.wake = 1'b0;

        // Write address and data captured in either order
        if (s_axi_awvalid && r_reg.awready) begin
            r_next.aw_have = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_reg.wready) begin
            r_next.w_have = 1'b1;
            r_next.w_data = s_axi_wdata[7:0];
            r_next.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
            r_next.aw_have = 1'b0;
            r_next.w_have = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = addr_ok(r_reg.aw_addr) ? wdt_pkg::RESP_OKAY
                                                  : wdt_pkg::RESP_SLVERR;
            if (r_reg.w_lane0) begin
                case (r_reg.aw_addr)
                    wdt_pkg::OFF_CTRL: begin
                        r_next.ps = r_reg.w_data[wdt_pkg::PS_MSB:
                                                 wdt_pkg::PS_LSB];
                        r_next.swen = r_reg.w_data[wdt_pkg::SWEN_BIT];
                    end
                    wdt_pkg::OFF_STAT: w1c = r_reg.w_data[1:0];
                    wdt_pkg::OFF_MASK: r_next.mask = r_reg.w_data[1:0];
                    wdt_pkg::OFF_FLAG: begin
                        if (r_reg.w_data[wdt_pkg::FLAG_EXP_BIT]) begin
                            r_next.expiry = 1'b0;
                        end
                        if (r_reg.w_data[wdt_pkg::FLAG_PD_BIT]) begin
                            r_next.powerdown = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
        r_next.awready = !r_next.aw_have && !r_next.bvalid;
        r_next.wready = !r_next.w_have && !r_next.bvalid;

        // Read channel
        if (s_axi_rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r_reg.arready) begin
            r_next.rvalid = 1'b1;
            r_next.rdata = rd_word(r_reg, s_axi_araddr);
            r_next.rresp = addr_ok(s_axi_araddr) ? wdt_pkg::RESP_OKAY
                                                 : wdt_pkg::RESP_SLVERR;
        end
        r_next.arready = !r_next.rvalid;

        // Sleep phase tracking
        case (r_reg.phase)
            wdt_pkg::PH_AWAKE: begin
                if (sleep_active) begin
                    r_next.phase = wdt_pkg::PH_ASLEEP;
                end
            end
            wdt_pkg::PH_ASLEEP: begin
                if (!sleep_active) begin
                    r_next.phase = wdt_pkg::PH_WAKING;
                end
            end
            wdt_pkg::PH_WAKING: begin
                if (sleep_active) begin
                    r_next.phase = wdt_pkg::PH_ASLEEP;
                end else if (!ost_running) begin
                    r_next.phase = wdt_pkg::PH_AWAKE;
                end
            end
            default: r_next.phase = wdt_pkg::PH_AWAKE;
        endcase

        // Time-out outcome, gated by present activity
        if (expire && active) begin
            r_next.expiry = 1'b1;
            if (asleep) begin
                r_next.wake = 1'b1;
                r_next.powerdown = 1'b1;
                ev[wdt_pkg::EV_WAKE_BIT] = 1'b1;
            end else begin
                r_next.sys_reset = 1'b1;
                ev[wdt_pkg::EV_RESET_BIT] = 1'b1;
            end
        end

        // Sticky status, set wins over clear
        r_next.status = (r_reg.status & ~w1c) | ev;
        r_next.irq = |(r_next.status & r_next.mask);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= STATE_RESET;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flops
    assign system_reset = r_reg.sys_reset;
    assign wake_request = r_reg.wake;
    assign expiry_flag = r_reg.expiry;
    assign powerdown_flag = r_reg.powerdown;
    assign irq = r_reg.irq;
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready = r_reg.wready;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;

    AST_RESET_AWAKE: assert property (@(posedge clk) disable iff (!nrst)
        (ce && expire && active && !asleep) |=> (system_reset && !wake_request))
        else $error("awake time-out gave no reset");
    AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (!nrst)
        (ce && expire && active && asleep)
        |=> (wake_request && !system_reset && expiry_flag && powerdown_flag))
        else $error("sleep time-out mishandled");
    AST_MODE_OFF: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_mode_select == wdt_pkg::MODE_DISABLED) |-> !active)
        else $error("disabled mode active");
    AST_MODE_ON: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_mode_select == wdt_pkg::MODE_ALWAYS_ACTIVE) |-> active)
        else $error("always mode inactive");
    AST_MODE_AWAKE: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_mode_select == wdt_pkg::MODE_ACTIVE_AWAKE_ONLY)
        |-> (active == !asleep))
        else $error("awake-only mode wrong");
    AST_MODE_SW: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_mode_select == wdt_pkg::MODE_SOFTWARE_CONTROLLED)
        |-> (active == r_reg.swen))
        else $error("software mode wrong");
    AST_PS_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (r_reg.ps == wdt_pkg::PS_DEFAULT))
        else $error("prescale not at default after reset");
    AST_SLEEP_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        (enter_sleep || exit_sleep) |-> cnt_clear)
        else $error("sleep edge did not clear");
    AST_OST_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        (r_reg.phase == wdt_pkg::PH_WAKING && ost_running) |-> cnt_clear)
        else $error("counter not held during startup timer");
    AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !(expire && active)) |=> !system_reset)
        else $error("reset without time-out");
endmodule : wdt_top
`default_nettype wire

// >>> wdt_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model #(
    parameter int TICK_DIV = 4,
    parameter int OST_LEN = 64
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sleep_req,
    input wire logic wake_req,
    input wire logic crystal,
    input wire logic wake_request,
    output var logic lf_osc_tick,
    output var logic sleep_active,
    output var logic ost_running
);
    int div_reg;
    int ost_reg;

    // Slow oscillator, shortened to one tick every TICK_DIV cycles
    always_ff @(posedge clk) begin
        if (!nrst || div_reg == TICK_DIV - 1) begin
            div_reg <= 0;
        end else begin
            div_reg <= div_reg + 1;
        end
        lf_osc_tick <= nrst && (div_reg == TICK_DIV - 1);
    end

    // Sleep state; a crystal clock restarts through the startup timer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sleep_active <= 1'b0;
            ost_reg <= 0;
        end else if (sleep_req) begin
            sleep_active <= 1'b1;
        end else if (sleep_active && (wake_request || wake_req)) begin
            sleep_active <= 1'b0;
            ost_reg <= crystal ? OST_LEN : 0;
        end else if (ost_reg != 0) begin
            ost_reg <= ost_reg - 1;
        end
    end

    assign ost_running = (ost_reg != 0);
endmodule : wdt_core_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode = 2'h3;
    logic clr = 1'b0;
    logic osc_fail = 1'b0;
    logic sleep_req = 1'b0;
    logic wake_req = 1'b0;
    logic crystal = 1'b0;
    logic tick, sleep_active, ost_running;
    logic system_reset, wake_request, expiry_flag, powerdown_flag, irq;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int miscompares = 0;
    int compares = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    wdt_core_model wdt_core_model_i (.clk(clk), .nrst(nrst),
        .sleep_req(sleep_req), .wake_req(wake_req), .crystal(crystal),
        .wake_request(wake_request), .lf_osc_tick(tick),
        .sleep_active(sleep_active), .ost_running(ost_running));

    wdt_top wdt_top_i (.clk(clk), .nrst(nrst), .ce(1'b1),
        .watchdog_mode_select(mode), .lf_osc_tick(tick),
        .clear_watchdog_instruction(clr), .sleep_active(sleep_active),
        .osc_fail(osc_fail), .ost_running(ost_running),
        .system_reset(system_reset), .wake_request(wake_request),
        .expiry_flag(expiry_flag), .powerdown_flag(powerdown_flag),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // Verdict and end of run
    task automatic results;
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tmo;
        miscompares++;
        $display("Error at %0t: wait ran out", $time);
        results();
    endtask : tmo

    // Bus write: address and data together, response awaited
    task automatic axw(input logic [31:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        bit aw = 1'b1;
        bit w = 1'b1;
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 200) begin
            @(posedge clk);
            n++;
            if (!aw && !w && bvalid === 1'b1) begin
                break;
            end
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (n >= 200) tmo();
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        // Let an edge pass so a following call never redrives bready at once
        @(posedge clk);
    endtask : axw

    // Bus read with data and response check
    task automatic axr(input logic [31:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        bit ar = 1'b1;
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 200) begin
            @(posedge clk);
            n++;
            if (!ar && rvalid === 1'b1) begin
                break;
            end
            if (ar && arready === 1'b1) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
        end
        if (n >= 200) tmo();
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        // Let an edge pass so a following call never redrives rready at once
        @(posedge clk);
    endtask : axr

    // Kick (0 clear, 1 sleep, 2 osc fail, 3 wake), then count ticks
    task automatic run(input int kind, input int nt, input int et,
                       input logic ewk);
        int ticks = 0;
        int lag = 0;
        int n = 0;
        bit ev = 1'b0;
        if (kind == 0) begin
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (3) @(posedge clk);
        end
        while (tick !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        clr <= (kind == 0);
        sleep_req <= (kind == 1);
        osc_fail <= (kind == 2);
        wake_req <= (kind == 3);
        @(posedge clk);
        clr <= 1'b0;
        sleep_req <= 1'b0;
        osc_fail <= 1'b0;
        wake_req <= 1'b0;
        while (!ev && ticks < nt) begin
            @(posedge clk);
            n++;
            lag++;
            if (n > 40000) tmo();
            if (tick === 1'b1) begin
                ticks++;
                lag = 0;
            end
            ev = (system_reset === 1'b1) || (wake_request === 1'b1);
        end
        if (et == 0) begin
            chk(32'(ev), 32'h0);
        end else begin
            chk(ticks, et);
            chk(lag, 32'h2);
            chk(32'(wake_request), 32'(ewk));
        end
    endtask : run

    // Reset values and unmapped access
    task automatic t_reset;
        axr(wdt_pkg::OFF_CTRL, 32'h16, wdt_pkg::RESP_OKAY);
        axr(wdt_pkg::OFF_MASK, 32'h0, wdt_pkg::RESP_OKAY);
        axr(32'h10, 32'h0, wdt_pkg::RESP_SLVERR);
        axw(32'h10, 32'hFF, wdt_pkg::RESP_SLVERR);
    endtask : t_reset

    // Time-out length per prescale code, reserved codes included
    task automatic t_periods;
        logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1F};
        int exp [6] = '{32, 64, 128, 256, 32, 32};
        for (int i = 0; i < 6; i++) begin
            axw(wdt_pkg::OFF_CTRL, {26'h0, codes[i], 1'b0},
                wdt_pkg::RESP_OKAY);
            run(0, exp[i] + 8, exp[i], 1'b0);
        end
        run(0, 28, 0, 1'b0);
        run(2, 28, 0, 1'b0);
    endtask : t_periods

    // Off mode and software controlled mode
    task automatic t_modes;
        mode <= wdt_pkg::MODE_DISABLED;
        axw(wdt_pkg::OFF_CTRL, 32'h1, wdt_pkg::RESP_OKAY);
        run(0, 40, 0, 1'b0);
        mode <= wdt_pkg::MODE_SOFTWARE_CONTROLLED;
        axw(wdt_pkg::OFF_CTRL, 32'h0, wdt_pkg::RESP_OKAY);
        run(0, 40, 0, 1'b0);
        axw(wdt_pkg::OFF_CTRL, 32'h1, wdt_pkg::RESP_OKAY);
        run(0, 40, 32, 1'b0);
    endtask : t_modes

    // Sleep entry and exit, wake on time-out, flags and interrupt
    task automatic t_sleep;
        mode <= wdt_pkg::MODE_ACTIVE_AWAKE_ONLY;
        run(1, 40, 0, 1'b0);
        run(3, 40, 32, 1'b0);
        mode <= wdt_pkg::MODE_ALWAYS_ACTIVE;
        axw(wdt_pkg::OFF_FLAG, 32'h3, wdt_pkg::RESP_OKAY);
        axw(wdt_pkg::OFF_STAT, 32'h3, wdt_pkg::RESP_OKAY);
        axw(wdt_pkg::OFF_MASK, 32'h2, wdt_pkg::RESP_OKAY);
        run(1, 40, 32, 1'b1);
        chk(32'({expiry_flag, powerdown_flag, irq}), 32'h7);
        axr(wdt_pkg::OFF_FLAG, 32'h3, wdt_pkg::RESP_OKAY);
        axr(wdt_pkg::OFF_STAT, 32'h2, wdt_pkg::RESP_OKAY);
        axw(wdt_pkg::OFF_STAT, 32'h2, wdt_pkg::RESP_OKAY);
        chk(32'(irq), 32'h0);
        crystal <= 1'b1;
        run(1, 10, 0, 1'b0);
        run(3, 60, 48, 1'b0);
    endtask : t_sleep

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_periods();
        t_modes();
        t_sleep();
        results();
    end
endmodule : tb
`default_nettype wire
